// *** include/dol_pkg.sv ***
// Shared constants for the deserializer output gating and lock block.
package dol_pkg;
   localparam int unsigned CLK_FREQ_HZ   = 25_000_000;
   localparam int unsigned LANES         = 3;
   localparam int unsigned BITS_PLAIN    = 7;
   localparam int unsigned BITS_BALANCED = 9;
   localparam int unsigned OUT_BITS      = LANES * BITS_PLAIN;
   // Longest gap between link clock rising edges before the clock counts as lost.
   localparam int unsigned LOSS_TIME_NS  = 2000;
   localparam int unsigned LOSS_CYCLES   =
      (LOSS_TIME_NS * (CLK_FREQ_HZ / 1_000_000)) / 1000;
   localparam int unsigned LOCK_PERIODS  = 32800;
   localparam int unsigned FIFO_DEPTH    = 8;
   // Balance tag in the two top bits of a nine bit word.
   localparam logic [1:0]  TAG_TRUE      = 2'h1;
   localparam logic [1:0]  TAG_INVERTED  = 2'h2;
   typedef enum logic [1:0] {
      DOL_OFF     = 2'h0,
      DOL_LOCKING = 2'h1,
      DOL_LOCKED  = 2'h3
   } dol_state_t;
endpackage

// *** logic/dol_fifo.sv ***
// Flip-flop FIFO with valid and ready on both sides and a synchronous flush.
`timescale 1ns/1ns
`default_nettype none
module dol_fifo #(
   parameter int unsigned WIDTH = 21,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
      $error("dol_fifo needs a power of two depth of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   always_comb begin
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count  = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
      if (flush) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count  = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // dol_fifo
`default_nettype wire

// *** logic/dol_top.sv ***
// Deserializer output gating, clock loss detection, lock counting and balance decode.
`timescale 1ns/1ns
`default_nettype none
module dol_top #(
   parameter int unsigned LOCK_PERIODS = dol_pkg::LOCK_PERIODS,
   parameter int unsigned FIFO_DEPTH   = dol_pkg::FIFO_DEPTH
) (
   input  wire logic                         clk,
   input  wire logic                         nrst,
   input  wire logic                         power_down_n,
   input  wire logic                         balance_mode_select,
   input  wire logic                         link_clock_in,
   input  wire logic [dol_pkg::LANES-1:0]    serial_lane_in,
   input  wire logic [dol_pkg::LANES-1:0]    lane_idle_in,
   input  wire logic                         clock_idle_in,
   output logic      [dol_pkg::OUT_BITS-1:0] parallel_data_out,
   output logic                              parallel_data_oe,
   output logic                              parallel_strobe_out,
   output logic                              parallel_strobe_oe,
   output logic                              locked
);
   localparam int unsigned LANES = dol_pkg::LANES;
   localparam int unsigned NB    = dol_pkg::BITS_PLAIN;
   localparam int unsigned WB    = dol_pkg::BITS_BALANCED;
   localparam int unsigned OB    = dol_pkg::OUT_BITS;

   if (LOCK_PERIODS < 1 || LOCK_PERIODS > 65535 || FIFO_DEPTH < 2) begin : g_bad_param
      $error("dol_top parameters out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and input synchronisers.
   logic [1:0]       rst_sync;
   logic             rst_n;
   logic [1:0]       pd_sync;
   logic [1:0]       mode_sync;
   logic [2:0]       lclk_sync;
   logic [LANES-1:0] lane_s1;
   logic [LANES-1:0] lane_s2;
   logic [LANES-1:0] idle_s1;
   logic [LANES-1:0] idle_s2;
   logic [1:0]       cidle_sync;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pd_sync    <= 2'h0;
         mode_sync  <= 2'h0;
         lclk_sync  <= 3'h0;
         lane_s1    <= '0;
         lane_s2    <= '0;
         idle_s1    <= '0;
         idle_s2    <= '0;
         cidle_sync <= 2'h0;
      end else begin
         pd_sync    <= {pd_sync[0], power_down_n};
         mode_sync  <= {mode_sync[0], balance_mode_select};
         lclk_sync  <= {lclk_sync[1:0], link_clock_in};
         lane_s1    <= serial_lane_in;
         lane_s2    <= lane_s1;
         idle_s1    <= lane_idle_in;
         idle_s2    <= idle_s1;
         cidle_sync <= {cidle_sync[0], clock_idle_in};
      end
   end

   logic pwr_on;
   logic balanced;
   logic link_edge;
   assign pwr_on    = pd_sync[1];
   assign balanced  = mode_sync[1];
   assign link_edge = lclk_sync[1] && !lclk_sync[2];

   ////////////////////////////////////////////////////////////////////////////
   // Clock loss detection and lock sequencing.
   localparam int unsigned GAP_W = $clog2(dol_pkg::LOSS_CYCLES + 1);

   dol_pkg::dol_state_t state;
   dol_pkg::dol_state_t next_state;
   logic [GAP_W-1:0]    gap;
   logic [GAP_W-1:0]    next_gap;
   logic [15:0]         lock_cnt;
   logic [15:0]         next_lock_cnt;
   logic                clk_lost;
   logic                fail_all;

   // A slow or stopped clock is seen as a long gap between rising edges.
   assign clk_lost = (gap == GAP_W'(dol_pkg::LOSS_CYCLES));
   assign fail_all = clk_lost || (!balanced && cidle_sync[1]);

   always_comb begin
      next_state    = state;
      next_gap      = gap;
      next_lock_cnt = lock_cnt;
      if (link_edge) begin
         next_gap = '0;
      end else if (!clk_lost) begin
         next_gap = gap + 1'b1;
      end
      case (state)
         dol_pkg::DOL_OFF: begin
            next_lock_cnt = '0;
            if (pwr_on) begin
               next_state = dol_pkg::DOL_LOCKING;
            end
         end
         dol_pkg::DOL_LOCKING: begin
            if (fail_all) begin
               next_lock_cnt = '0;
            end else if (link_edge) begin
               next_lock_cnt = lock_cnt + 1'b1;
            end
            if (!fail_all && link_edge && lock_cnt == 16'(LOCK_PERIODS - 1)) begin
               next_state = dol_pkg::DOL_LOCKED;
            end
         end
         dol_pkg::DOL_LOCKED: begin
            if (fail_all) begin
               next_state    = dol_pkg::DOL_LOCKING;
               next_lock_cnt = '0;
            end
         end
         default: begin
            next_state = dol_pkg::DOL_OFF;
         end
      endcase
      if (!pwr_on) begin
         next_state = dol_pkg::DOL_OFF;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= dol_pkg::DOL_OFF;
         gap      <= '0;
         lock_cnt <= 16'h0;
      end else begin
         state    <= next_state;
         gap      <= next_gap;
         lock_cnt <= next_lock_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial capture and balance decode, one bit per clock cycle per lane.
   // The capture window is only as deep as a balanced word, so the link period
   // must be at least nine clock cycles for balanced words to be whole.
   logic [WB-1:0] shift      [LANES];
   logic [WB-1:0] next_shift [LANES];
   logic [OB-1:0] word;
   logic          fifo_in_ready;
   logic [OB-1:0] fifo_out_data;
   logic          fifo_out_valid;

   always_comb begin
      word = '0;
      for (int i = 0; i < LANES; i++) begin
         next_shift[i] = {shift[i][WB-2:0], lane_s2[i]};
         if (balanced) begin
            // Tag bits arrive first; an inverted tag restores the true polarity.
            if (shift[i][WB-1:NB] == dol_pkg::TAG_INVERTED) begin
               word[i*NB +: NB] = ~shift[i][NB-1:0];
            end else begin
               word[i*NB +: NB] = shift[i][NB-1:0];
            end
         end else begin
            word[i*NB +: NB] = shift[i][NB-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < LANES; i++) begin
            shift[i] <= '0;
         end
      end else begin
         for (int i = 0; i < LANES; i++) begin
            shift[i] <= next_shift[i];
         end
      end
   end

   // Words wait here until the next strobe; the queue empties while unlocked.
   dol_fifo #(
      .WIDTH (OB),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (state != dol_pkg::DOL_LOCKED),
      .in_data   (word),
      .in_valid  (link_edge && state == dol_pkg::DOL_LOCKED),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (link_edge)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output gating.
   logic [OB-1:0] next_data;
   logic          next_strobe;
   logic          next_oe;
   logic          next_locked;

   always_comb begin
      next_oe     = pwr_on && state != dol_pkg::DOL_OFF;
      // Lock falls with the enables, so it is never shown on released pins.
      next_locked = pwr_on && state == dol_pkg::DOL_LOCKED;
      next_data   = parallel_data_out;
      if (link_edge && fifo_out_valid) begin
         next_data = fifo_out_data;
      end
      next_strobe = lclk_sync[1] && next_locked && !fail_all;
      if (!next_locked || fail_all || !next_oe) begin
         next_data = '0;
      end
      for (int i = 0; i < LANES; i++) begin
         if (!balanced && idle_s2[i]) begin
            next_data[i*NB +: NB] = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         parallel_data_out   <= '0;
         parallel_strobe_out <= 1'b0;
         parallel_data_oe    <= 1'b0;
         parallel_strobe_oe  <= 1'b0;
         locked              <= 1'b0;
      end else begin
         parallel_data_out   <= next_data;
         parallel_strobe_out <= next_strobe;
         parallel_data_oe    <= next_oe;
         parallel_strobe_oe  <= next_oe;
         locked              <= next_locked;
      end
   end

   // Every push after the first meets a pop on the same strobe edge, so the queue
   // never holds more than one word; in_ready is kept for structural completeness.
   logic unused_ready;
   assign unused_ready = fifo_in_ready;
endmodule // dol_top
`default_nettype wire

// *** verification/dol_ser_model.sv ***
// Behavioural serializer that drives the link clock and the three serial lanes.
`timescale 1ns/1ns
`default_nettype none
module dol_ser_model (
   input  wire logic       run,
   output logic            link_clk,
   output logic [2:0]      lanes
);
   // Each lane repeats one eight bit word per link period, first bit with the rising edge.
   // The balanced window takes nine samples, so its first tag bit is the previous word's
   // last bit; repeating the word keeps that tag meaningful at this period.
   localparam logic [7:0] PAT0 = 8'h59;
   localparam logic [7:0] PAT1 = 8'hb4;
   localparam logic [7:0] PAT2 = 8'he3;
   int unsigned slot;
   // Outside traffic the clock stands low and the lanes toggle, so no stale value lingers.
   initial begin
      link_clk = 1'b0;
      lanes    = 3'h5;
      slot     = 0;
      #17;
      forever begin
         if (run) begin
            link_clk = (slot < 4);
            lanes    = {PAT2[7-slot], PAT1[7-slot], PAT0[7-slot]};
            slot     = (slot + 1) % 8;
         end else begin
            link_clk = 1'b0;
            lanes    = ~lanes;
            slot     = 0;
         end
         #40;
      end
   end
endmodule // dol_ser_model
`default_nettype wire

// *** verification/dol_top_chk.sv ***
// Concurrent checks on the ports of the output gating and lock block.
`timescale 1ns/1ns
`default_nettype none
module dol_top_chk #(
   parameter int unsigned LOCK_PERIODS = 4,
   parameter int unsigned FIFO_DEPTH   = 8
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        power_down_n,
   input  wire logic        balance_mode_select,
   input  wire logic        link_clock_in,
   input  wire logic [2:0]  lane_idle_in,
   input  wire logic        clock_idle_in,
   input  wire logic [20:0] parallel_data_out,
   input  wire logic        parallel_data_oe,
   input  wire logic        parallel_strobe_out,
   input  wire logic        parallel_strobe_oe,
   input  wire logic        locked
);
   logic [6:0] gap_cnt;
   logic [6:0] next_gap_cnt;
   logic [6:0] idle_cnt;
   logic [6:0] next_idle_cnt;
   logic       link_q;
   ////////////////////////////////////////////////////////////////////////////////
   // Counters saturate so a long stall cannot wrap back into a quiet window.
   always_comb begin
      next_gap_cnt = (link_clock_in != link_q) ? 7'h00 : gap_cnt + 7'(gap_cnt != 7'h7f);
      next_idle_cnt = (balance_mode_select || !lane_idle_in[1]) ? 7'h00
                      : idle_cnt + 7'(idle_cnt != 7'h7f);
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap_cnt <= 7'h00;
         idle_cnt <= 7'h00;
         link_q <= 1'b0;
      end else begin
         gap_cnt <= next_gap_cnt;
         idle_cnt <= next_idle_cnt;
         link_q <= link_clock_in;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   pd_off_a: assert property (!power_down_n [*4] |-> !parallel_data_oe && !locked)
      else $error("outputs still driven in power down");
   oe_pair_a: assert property (parallel_data_oe |->
                               parallel_strobe_oe && $past(power_down_n, 3))
      else $error("enables differ or driven without power");
   unlocked_low_a: assert property (!locked [*2] |->
                                    parallel_data_out == 21'h0 && !parallel_strobe_out)
      else $error("outputs not low while unlocked");
   lock_oe_a: assert property (locked |-> parallel_data_oe)
      else $error("lock shown with outputs released");
   lock_early_a: assert property ($rose(parallel_data_oe) |-> !locked [*8])
      else $error("lock declared too early");
   link_stop_a: assert property (gap_cnt >= 7'd60 |->
                                 !locked && parallel_data_out == 21'h0)
      else $error("stopped link clock not detected");
   lane_idle_a: assert property (idle_cnt >= 7'd24 |->
                                 parallel_data_out[13:7] == 7'h00)
      else $error("idle lane not forced low");
   clk_idle_a: assert property ((clock_idle_in && !balance_mode_select) [*8] |->
                                !locked && parallel_data_out == 21'h0)
      else $error("idle clock input not forced low");
endmodule // dol_top_chk
bind dol_top dol_top_chk #(.LOCK_PERIODS(LOCK_PERIODS), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
   .clk(clk), .nrst(nrst), .power_down_n(power_down_n),
   .balance_mode_select(balance_mode_select), .link_clock_in(link_clock_in),
   .lane_idle_in(lane_idle_in), .clock_idle_in(clock_idle_in),
   .parallel_data_out(parallel_data_out), .parallel_data_oe(parallel_data_oe),
   .parallel_strobe_out(parallel_strobe_out), .parallel_strobe_oe(parallel_strobe_oe),
   .locked(locked));
`default_nettype wire

// *** verification/dol_top_tb_top.sv ***
// Self-checking bench for the output gating and lock block.
`timescale 1ns/1ns
`default_nettype none
module dol_top_tb_top;
   localparam int unsigned LOCKP = 4;
   // Words of the serializer model: plain keeps each lane's last seven bits, balanced
   // inverts lane 0 whose tag is 10, and an idle lane 1 clears bits 13 to 7.
   localparam logic [20:0] PLAIN_WORD = 21'h18da59;
   localparam logic [20:0] BAL_WORD   = 21'h18da26;
   localparam logic [20:0] LANE1_IDLE = 21'h18c059;
   logic        clk;
   logic        nrst;
   logic        power_down_n;
   logic        balance_mode_select;
   logic        clock_idle_in;
   logic        run;
   logic [2:0]  lane_idle_in;
   logic        link_clock_in;
   logic [2:0]  serial_lane_in;
   logic [20:0] parallel_data_out;
   logic        parallel_data_oe;
   logic        parallel_strobe_out;
   logic        parallel_strobe_oe;
   logic        locked;
   int          errors;
   int          compares;
   int          cycles;
   dol_ser_model i_ser (.run(run), .link_clk(link_clock_in), .lanes(serial_lane_in));
   dol_top #(.LOCK_PERIODS(LOCKP), .FIFO_DEPTH(8)) i_dut (
      .clk(clk), .nrst(nrst), .power_down_n(power_down_n),
      .balance_mode_select(balance_mode_select), .link_clock_in(link_clock_in),
      .serial_lane_in(serial_lane_in), .lane_idle_in(lane_idle_in),
      .clock_idle_in(clock_idle_in), .parallel_data_out(parallel_data_out),
      .parallel_data_oe(parallel_data_oe), .parallel_strobe_out(parallel_strobe_out),
      .parallel_strobe_oe(parallel_strobe_oe), .locked(locked));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [20:0] seen, input logic [20:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask
   // The bound allows the full count plus three link periods for sync and restart.
   task automatic wait_lock();
      for (int i = 0; i < (LOCKP + 3) * 8 && locked !== 1'b1; i++) @(negedge clk);
   endtask
   task automatic results();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_pd();
      power_down_n = 1'b0;
      wait_clk(4);
      check(21'(parallel_data_oe), 21'h0);
      check(21'(parallel_strobe_oe), 21'h0);
      check(21'(locked), 21'h0);
      $display("power down test done");
   endtask
   // Release first and apply the clock later, the awkward order.
   // Power-down has been low for at least four cycles here, past the 100 ns gap.
   task automatic t_lock();
      logic [20:0] highs;
      run = 1'b0;
      power_down_n = 1'b1;
      wait_clk(6);
      check(21'(parallel_data_oe), 21'h1);
      check(parallel_data_out, 21'h0);
      run = 1'b1;
      wait_lock();
      check(21'(locked), 21'h1);
      wait_clk(24);
      check(parallel_data_out, PLAIN_WORD);
      highs = 21'h0;
      repeat (8) begin
         @(negedge clk);
         highs = highs + 21'(parallel_strobe_out);
      end
      check(highs, 21'h4);
      $display("lock test done");
   endtask
   task automatic t_lane();
      lane_idle_in = 3'h2;
      wait_clk(24);
      check(parallel_data_out, LANE1_IDLE);
      lane_idle_in = 3'h0;
      $display("lane idle test done");
   endtask
   task automatic t_bal();
      balance_mode_select = 1'b1;
      lane_idle_in = 3'h7;
      clock_idle_in = 1'b1;
      wait_clk(32);
      check(21'(locked), 21'h1);
      check(parallel_data_out, BAL_WORD);
      lane_idle_in = 3'h0;
      clock_idle_in = 1'b0;
      balance_mode_select = 1'b0;
      wait_clk(24);
      check(parallel_data_out, PLAIN_WORD);
      $display("balanced test done");
   endtask
   task automatic t_cidle();
      clock_idle_in = 1'b1;
      wait_clk(8);
      check(21'(locked), 21'h0);
      check(parallel_data_out, 21'h0);
      check(21'(parallel_strobe_out), 21'h0);
      clock_idle_in = 1'b0;
      wait_lock();
      check(21'(locked), 21'h1);
      $display("clock idle test done");
   endtask
   task automatic t_stop();
      run = 1'b0;
      wait_clk(70);
      check(21'(locked), 21'h0);
      check(parallel_data_out, 21'h0);
      run = 1'b1;
      wait_lock();
      check(21'(locked), 21'h1);
      $display("clock stop test done");
   endtask
   initial begin
      errors = 0;
      compares = 0;
      cycles = 0;
      nrst = 1'b0;
      power_down_n = 1'b0;
      balance_mode_select = 1'b0;
      clock_idle_in = 1'b0;
      lane_idle_in = 3'h0;
      run = 1'b1;
      wait_clk(6);
      nrst = 1'b1;
      t_pd();
      t_lock();
      t_lane();
      t_bal();
      t_cidle();
      t_stop();
      t_pd();
      results();
   end
endmodule // dol_top_tb_top
`default_nettype wire
